// ===== src/ssq_params.svh
// constants for the square root sequencer
`ifndef SSQ_PARAMS_SVH
`define SSQ_PARAMS_SVH

// ********************
// register map
// ********************
`define SSQ_ADDR_CTRL    8'h00
`define SSQ_ADDR_STAT    8'h04
`define SSQ_CTRL_START   0
`define SSQ_CTRL_ODD     1
`define SSQ_STAT_PH_LSB  0
`define SSQ_STAT_LO      7
`define SSQ_STAT_CLR     8
`define SSQ_STAT_TAL_LSB 9
`define SSQ_STAT_C_LSB   16
`define SSQ_RESP_OKAY    2'h0
`define SSQ_RESP_SLVERR  2'h2

// ********************
// digit pointer figures
// ********************
`define SSQ_C_EVEN       5'h16
`define SSQ_C_ODD        5'h17
`define SSQ_C_TOP        5'h17
`define SSQ_C_SPAN       5'h18
`define SSQ_C_ZERO       5'h00

`endif

// ===== src/ssq_pkg.sv
// types shared by the square root sequencer
`default_nettype none
package ssq_pkg;

  // cycle-phase counter, one-hot
  typedef enum logic [6:0] {
    PH_OFF      = 7'h01,
    PH_SETUP    = 7'h02,
    PH_IDLE     = 7'h04,
    PH_DOUBLE   = 7'h08,
    PH_SUBTRACT = 7'h10,
    PH_RESTORE  = 7'h20,
    PH_RECORD   = 7'h40
  } ssq_phase_t;

  // steering lines towards the adder and the storage registers
  typedef struct packed {
    logic clr_entry;
    logic clr_quot;
    logic adder_gate_first;
    logic adder_gate_second;
    logic entry_write;
    logic acc_subtract;
    logic acc_restore;
    logic quot_write_sel;
    logic quot_write_right;
    logic quot_shift_right;
    logic acc_shift_left;
  } ssq_ctl_t;

endpackage
`default_nettype wire

// ===== src/ssq_sequencer.sv
// square root sequencer with its axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "ssq_params.svh"

module ssq_sequencer (
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  // timing chain and adder, same clock
  input  wire logic [4:0]        digit_count_i,
  input  wire logic              units_digit_strobe_i,
  input  wire logic              word_end_i,
  input  wire logic              remainder_neg_i,
  output logic                   digit_select_strobe_o,
  output logic                   next_digit_strobe_o,
  output ssq_pkg::ssq_ctl_t      ctl_o,
  output logic [3:0]             tally_o,
  output logic                   busy_o,
  // axi4-lite slave
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [7:0]        s_axi_awaddr_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  output logic [1:0]             s_axi_bresp_o,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  input  wire logic [7:0]        s_axi_araddr_i,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o
);

  // ********************
  // state
  // ********************
  ssq_pkg::ssq_phase_t phase_q;
  logic [4:0]          c_q;
  logic [3:0]          tally_q;
  logic                low_order_flag_q;
  logic                clear_flag_q;
  logic                odd_q;
  logic                start_q;
  logic                finish;
  logic                aw_q;
  logic                w_q;
  logic [7:0]          awaddr_q;
  logic [31:0]         wdata_q;
  logic                wstrb0_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;
  logic                wr_go;

  // pointer step with wrap at the bottom of the 24-digit range
  function automatic logic [4:0] ssq_dec(input logic [4:0] c,
                                         input logic [4:0] n);
    logic [4:0] r;
    r = (c < n) ? c + `SSQ_C_SPAN - n : c - n;
    return r;
  endfunction

  // ********************
  // digit strobes
  // ********************
  // c counter is ours, so the strobes are compared here, no extra delay
  assign digit_select_strobe_o = (digit_count_i == c_q);
  assign next_digit_strobe_o   = (digit_count_i == c_q + 5'h01);

  // end check at the first look into subtract, before any arithmetic
  assign finish = (phase_q == ssq_pkg::PH_SUBTRACT) && clear_flag_q
                  && (c_q == `SSQ_C_TOP);

  // ********************
  // phase counter
  // ********************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= ssq_pkg::PH_OFF;
    end else if (finish) begin
      phase_q <= ssq_pkg::PH_OFF;
    end else begin
      unique case (phase_q)
        ssq_pkg::PH_OFF: begin
          if (start_q) begin
            phase_q <= ssq_pkg::PH_SETUP;
          end
        end
        ssq_pkg::PH_SETUP: begin
          if (word_end_i) begin
            phase_q <= ssq_pkg::PH_IDLE;
          end
        end
        ssq_pkg::PH_IDLE: begin
          if (word_end_i) begin
            phase_q <= ssq_pkg::PH_DOUBLE;
          end
        end
        ssq_pkg::PH_DOUBLE: begin
          if (word_end_i) begin
            phase_q <= ssq_pkg::PH_SUBTRACT;
          end
        end
        ssq_pkg::PH_SUBTRACT: begin
          if (word_end_i && remainder_neg_i) begin
            phase_q <= ssq_pkg::PH_RESTORE;
          end
        end
        ssq_pkg::PH_RESTORE: begin
          if (word_end_i) begin
            phase_q <= ssq_pkg::PH_RECORD;
          end
        end
        ssq_pkg::PH_RECORD: begin
          if (word_end_i) begin
            phase_q <= ssq_pkg::PH_DOUBLE;
          end
        end
        default: begin
          phase_q <= ssq_pkg::PH_OFF;
        end
      endcase
    end
  end

  // ********************
  // digit pointer
  // ********************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c_q <= `SSQ_C_ZERO;
    end else if (phase_q == ssq_pkg::PH_OFF && start_q) begin
      c_q <= odd_q ? `SSQ_C_ODD : `SSQ_C_EVEN;
    end else if (phase_q == ssq_pkg::PH_RECORD && word_end_i) begin
      // single steps once the units digit is placed
      c_q <= ssq_dec(c_q, low_order_flag_q ? 5'h01 : 5'h02);
    end
  end

  // ********************
  // digit tally
  // ********************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tally_q <= 4'h0;
    end else if (phase_q == ssq_pkg::PH_OFF && start_q) begin
      tally_q <= 4'h0;
    end else if (phase_q == ssq_pkg::PH_SUBTRACT && word_end_i
                 && !remainder_neg_i && !finish) begin
      tally_q <= tally_q + 4'h1;
    end else if (phase_q == ssq_pkg::PH_RECORD && word_end_i) begin
      tally_q <= 4'h0;
    end
  end

  // ********************
  // low-order and clear flags
  // ********************
  // both live for the whole routine and drop only at the next start
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_order_flag_q <= 1'b0;
      clear_flag_q     <= 1'b0;
    end else if (phase_q == ssq_pkg::PH_OFF && start_q) begin
      low_order_flag_q <= 1'b0;
      clear_flag_q     <= 1'b0;
    end else begin
      if (phase_q == ssq_pkg::PH_RESTORE && digit_select_strobe_o
          && units_digit_strobe_i) begin
        low_order_flag_q <= 1'b1;
      end
      if (phase_q == ssq_pkg::PH_SUBTRACT && c_q == `SSQ_C_ZERO) begin
        clear_flag_q <= 1'b1;
      end
    end
  end

  // ********************
  // steering decode
  // ********************
  // decoded from flops only; the adder samples it per bit time
  always_comb begin
    ctl_o = '0;
    unique case (phase_q)
      ssq_pkg::PH_SETUP: begin
        ctl_o.clr_entry = 1'b1;
        ctl_o.clr_quot  = 1'b1;
      end
      ssq_pkg::PH_DOUBLE: begin
        ctl_o.adder_gate_first  = 1'b1;
        ctl_o.adder_gate_second = 1'b1;
        ctl_o.entry_write       = 1'b1;
      end
      ssq_pkg::PH_SUBTRACT: begin
        ctl_o.acc_subtract = !finish;
      end
      ssq_pkg::PH_RESTORE: begin
        ctl_o.acc_restore = 1'b1;
      end
      ssq_pkg::PH_RECORD: begin
        ctl_o.quot_write_sel   = low_order_flag_q;
        ctl_o.acc_shift_left   = low_order_flag_q;
        ctl_o.quot_write_right = !low_order_flag_q;
        ctl_o.quot_shift_right = !low_order_flag_q;
      end
      default: begin
        ctl_o = '0;
      end
    endcase
  end

  assign tally_o = tally_q;
  assign busy_o  = (phase_q != ssq_pkg::PH_OFF);

  // ********************
  // axi4-lite write side
  // ********************
  assign s_axi_awready_o = !aw_q && !bvalid_q;
  assign s_axi_wready_o  = !w_q && !bvalid_q;
  assign wr_go           = aw_q && w_q && !bvalid_q;

  // address and data may land in either order
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0;
      wstrb0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end else if (wr_go) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_q      <= 1'b1;
        wdata_q  <= s_axi_wdata_i;
        wstrb0_q <= s_axi_wstrb_i[0];
      end else if (wr_go) begin
        w_q <= 1'b0;
      end
    end
  end

  // control register: start is a one-shot, ignored while busy
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_q <= 1'b0;
      odd_q   <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (wr_go && awaddr_q == `SSQ_ADDR_CTRL && wstrb0_q && !busy_o) begin
        start_q <= wdata_q[`SSQ_CTRL_START];
        odd_q   <= wdata_q[`SSQ_CTRL_ODD];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `SSQ_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (awaddr_q == `SSQ_ADDR_CTRL) ? `SSQ_RESP_OKAY
                                               : `SSQ_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o  = bresp_q;

  // ********************
  // axi4-lite read side
  // ********************
  assign s_axi_arready_o = !rvalid_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= `SSQ_RESP_OKAY;
    end else if (s_axi_arvalid_i && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= 32'h0;
      rresp_q  <= `SSQ_RESP_OKAY;
      if (s_axi_araddr_i == `SSQ_ADDR_CTRL) begin
        rdata_q[`SSQ_CTRL_ODD] <= odd_q;
      end else if (s_axi_araddr_i == `SSQ_ADDR_STAT) begin
        rdata_q[`SSQ_STAT_PH_LSB +: 7] <= phase_q;
        rdata_q[`SSQ_STAT_LO]          <= low_order_flag_q;
        rdata_q[`SSQ_STAT_CLR]         <= clear_flag_q;
        rdata_q[`SSQ_STAT_TAL_LSB +: 4] <= tally_q;
        rdata_q[`SSQ_STAT_C_LSB +: 5]  <= c_q;
      end else begin
        rresp_q <= `SSQ_RESP_SLVERR;
      end
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o  = rdata_q;
  assign s_axi_rresp_o  = rresp_q;

  // ********************
  // assertions
  // ********************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  setup_preset_a: assert property (phase_q == ssq_pkg::PH_SETUP |-> c_q == (odd_q ? 5'h17 : 5'h16)) else $error("bad preset");
  setup_clear_a: assert property (phase_q == ssq_pkg::PH_SETUP |-> ctl_o.clr_entry && ctl_o.clr_quot) else $error("setup clear missing");
  setup_idle_a: assert property (phase_q == ssq_pkg::PH_SETUP && word_end_i |=> phase_q == ssq_pkg::PH_IDLE && !ctl_o.acc_subtract) else $error("setup exit wrong");
  double_gates_a: assert property (phase_q == ssq_pkg::PH_DOUBLE |-> ctl_o.adder_gate_first && ctl_o.adder_gate_second && ctl_o.entry_write) else $error("doubling gates off");
  tally_step_a: assert property (phase_q == ssq_pkg::PH_SUBTRACT && word_end_i && !remainder_neg_i && !finish |=> tally_q == $past(tally_q) + 4'h1 && phase_q == ssq_pkg::PH_SUBTRACT) else $error("tally step wrong");
  neg_restore_a: assert property (phase_q == ssq_pkg::PH_SUBTRACT && word_end_i && remainder_neg_i && !finish |=> phase_q == ssq_pkg::PH_RESTORE ##0 ctl_o.acc_restore) else $error("no restore");
  clear_set_a: assert property (phase_q == ssq_pkg::PH_SUBTRACT && c_q == 5'h00 |=> clear_flag_q) else $error("clear flag not set");
  routine_end_a: assert property (finish |-> !ctl_o.acc_subtract ##1 phase_q == ssq_pkg::PH_OFF && !busy_o) else $error("routine did not end");
  lo_set_a: assert property (phase_q == ssq_pkg::PH_RESTORE && digit_select_strobe_o && units_digit_strobe_i |=> low_order_flag_q) else $error("low flag not set");
  restore_one_a: assert property (phase_q == ssq_pkg::PH_RESTORE && word_end_i |=> phase_q == ssq_pkg::PH_RECORD) else $error("restore overstayed");
  record_step_a: assert property (phase_q == ssq_pkg::PH_RECORD && word_end_i |=> c_q == ssq_dec($past(c_q), $past(low_order_flag_q) ? 5'h01 : 5'h02) && phase_q == ssq_pkg::PH_DOUBLE && tally_q == 4'h0) else $error("record step wrong");
  pointer_range_a: assert property (c_q <= 5'h17) else $error("pointer out of range");

endmodule
`default_nettype wire

// ===== tb/ssq_chain_model.sv
// timing chain and remainder sign model facing the square root sequencer
`timescale 1ns/1ps
`default_nettype none
module ssq_chain_model (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic [4:0] units_pos_i,
  input  wire logic [3:0] neg_after_i,
  input  wire logic       acc_subtract_i,
  output logic [4:0]      digit_count_o,
  output logic            units_digit_strobe_o,
  output logic            word_end_o,
  output logic            remainder_neg_o
);
  // ********************
  // chain and adder sign
  // ********************
  logic [3:0] nsub_q;
  // digit counter runs free, one clock a digit, thirty digits a word
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) digit_count_o <= 5'h00;
    else digit_count_o <= word_end_o ? 5'h00 : digit_count_o + 5'h01;
  end
  // positive subtract words so far; forgotten once subtract ends
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) nsub_q <= 4'h0;
    else if (!acc_subtract_i) nsub_q <= 4'h0;
    else if (word_end_o) nsub_q <= nsub_q + 4'h1;
  end
  // sign only means something while a subtraction is steered
  assign word_end_o           = digit_count_o == 5'h1d;
  assign units_digit_strobe_o = digit_count_o == units_pos_i;
  assign remainder_neg_o      = acc_subtract_i && (nsub_q >= neg_after_i);
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the square root sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ssq_params.svh"
module tb_top;
  // ********************
  // signals and parts
  // ********************
  logic clk = 1'b0, rst_n = 1'b0, wend, ustr, rneg, dsel, dnext, busy;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic awr, wr, bv, arr, rv;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, s;
  logic [1:0] bresp, rresp;
  logic [4:0] dcount, units = 5'h0c, eptr;
  logic [3:0] kneg = 4'h0, tal, etal, ensub;
  logic [3:0] ws = 4'hf;
  logic elo, eclr;
  ssq_pkg::ssq_ctl_t ctl;
  ssq_pkg::ssq_phase_t eph;
  int n_mismatch = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  ssq_sequencer dut (.mclk_i(clk), .rst_n_i(rst_n), .digit_count_i(dcount),
    .units_digit_strobe_i(ustr), .word_end_i(wend), .remainder_neg_i(rneg),
    .digit_select_strobe_o(dsel), .next_digit_strobe_o(dnext), .ctl_o(ctl),
    .tally_o(tal), .busy_o(busy), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .s_axi_rdata_o(rd),
    .s_axi_rresp_o(rresp));
  ssq_chain_model chain (.mclk_i(clk), .rst_n_i(rst_n), .units_pos_i(units),
    .neg_after_i(kneg), .acc_subtract_i(ctl.acc_subtract),
    .digit_count_o(dcount), .units_digit_strobe_o(ustr), .word_end_o(wend),
    .remainder_neg_o(rneg));
  // ********************
  // tasks
  // ********************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // handshakes judged at the falling edge, released after the rising one
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic ha, hw, hb, done;
    done = 1'b0;
    @(posedge clk);
    awv <= 1'b1; wv <= 1'b1; br <= 1'b1; awa <= a; wd <= d;
    for (int i = 0; i < 50 && !done; i++) begin
      @(negedge clk);
      ha = awv && awr; hw = wv && wr; hb = bv && br;
      if (hb) check(bresp, er);
      @(posedge clk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
      if (hb) br <= 1'b0;
      done = hb;
    end
    check(done, 1'b1);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        input logic [1:0] er);
    logic har, hr, done;
    done = 1'b0;
    @(posedge clk);
    arv <= 1'b1; rr <= 1'b1; ara <= a;
    for (int i = 0; i < 50 && !done; i++) begin
      @(negedge clk);
      har = arv && arr; hr = rv && rr; d = rd;
      if (hr) check(rresp, er);
      @(posedge clk);
      if (har) arv <= 1'b0;
      if (hr) rr <= 1'b0;
      done = hr;
    end
    check(done, 1'b1);
  endtask
  // steering expected in the phase the bench believes the routine is in
  function automatic ssq_pkg::ssq_ctl_t exp_ctl();
    ssq_pkg::ssq_ctl_t c;
    c = '0;
    case (eph)
      ssq_pkg::PH_SETUP: {c.clr_entry, c.clr_quot} = 2'h3;
      ssq_pkg::PH_DOUBLE: {c.adder_gate_first, c.adder_gate_second,
                           c.entry_write} = 3'h7;
      ssq_pkg::PH_SUBTRACT: c.acc_subtract = !(eptr == 5'h17 && eclr);
      ssq_pkg::PH_RESTORE: c.acc_restore = 1'b1;
      ssq_pkg::PH_RECORD: if (elo) {c.quot_write_sel, c.acc_shift_left} = 2'h3;
        else {c.quot_write_right, c.quot_shift_right} = 2'h3;
      default: ;
    endcase
    return c;
  endfunction
  task automatic cmp_stat();
    axi_rd(`SSQ_ADDR_STAT, s, `SSQ_RESP_OKAY);
    // live outputs looked at mid-cycle, away from the edge that moves them
    @(negedge clk);
    check(s[6:0], eph);
    check(busy, eph != ssq_pkg::PH_OFF);
    if (eph != ssq_pkg::PH_OFF) begin
      check(s[20:16], eptr);
      check(s[12:9], etal);
      check(tal, etal);
      check(s[7], elo);
      check(ctl, exp_ctl());
    end
    if (eph inside {ssq_pkg::PH_RESTORE, ssq_pkg::PH_RECORD,
                    ssq_pkg::PH_DOUBLE}) check(s[8], eclr);
  endtask
  // one word: strobes watched, bench model stepped, status compared
  task automatic step();
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
      if (eph == ssq_pkg::PH_SUBTRACT) begin
        check(dsel, dcount == eptr);
        check(dnext, dcount == eptr + 5'h01);
      end
    end while (!wend && i < 40);
    @(posedge clk);
    case (eph)
      ssq_pkg::PH_SETUP: eph = ssq_pkg::PH_IDLE;
      ssq_pkg::PH_IDLE: eph = ssq_pkg::PH_DOUBLE;
      ssq_pkg::PH_DOUBLE: begin
        // end check fires on the first subtract clock, off before the read
        eph = (eptr == 5'h17 && eclr) ? ssq_pkg::PH_OFF
                                      : ssq_pkg::PH_SUBTRACT;
        ensub = 4'h0;
      end
      ssq_pkg::PH_SUBTRACT: if (eptr == 5'h17 && eclr) eph = ssq_pkg::PH_OFF;
        else begin
          if (eptr == 5'h00) eclr = 1'b1;
          if (ensub < kneg) {etal, ensub} = {etal + 4'h1, ensub + 4'h1};
          else eph = ssq_pkg::PH_RESTORE;
        end
      ssq_pkg::PH_RESTORE: begin
        if (eptr == units) elo = 1'b1;
        eph = ssq_pkg::PH_RECORD;
      end
      ssq_pkg::PH_RECORD: begin
        eptr = elo ? (eptr == 5'h00 ? 5'h17 : eptr - 5'h01) : eptr - 5'h02;
        etal = 4'h0;
        eph = ssq_pkg::PH_DOUBLE;
      end
      default: ;
    endcase
    @(posedge clk);
    cmp_stat();
  endtask
  // a whole root from start to the routine ending by itself
  task automatic run_root(input logic odd, input logic [3:0] k,
                          input logic [4:0] u);
    kneg <= k;
    units <= u;
    @(posedge clk iff dcount == 5'h03);
    axi_wr(`SSQ_ADDR_CTRL, {30'h0, odd, 1'b1}, `SSQ_RESP_OKAY);
    {eph, eptr} = {ssq_pkg::PH_SETUP, odd ? `SSQ_C_ODD : `SSQ_C_EVEN};
    {etal, elo, eclr} = '0;
    cmp_stat();
    // a start while busy is ignored, so the routine must carry on
    if (odd) axi_wr(`SSQ_ADDR_CTRL, 32'h3, `SSQ_RESP_OKAY);
    axi_rd(`SSQ_ADDR_CTRL, s, `SSQ_RESP_OKAY);
    check(s, {30'h0, odd, 1'b0});
    for (int n = 0; n < 300 && eph != ssq_pkg::PH_OFF; n++) step();
    $display("root run ended, odd units %0d", odd);
  endtask
  // ********************
  // sequence
  // ********************
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(`SSQ_ADDR_STAT, s, `SSQ_RESP_OKAY);
    check(s, 32'h1);
    axi_rd(8'h08, s, `SSQ_RESP_SLVERR);
    check(s, 32'h0);
    axi_wr(8'h0c, 32'h1, `SSQ_RESP_SLVERR);
    axi_rd(`SSQ_ADDR_STAT, s, `SSQ_RESP_OKAY);
    check(s, 32'h1);
    // a start with its low byte lane off must be dropped
    ws <= 4'h0;
    axi_wr(`SSQ_ADDR_CTRL, 32'h1, `SSQ_RESP_OKAY);
    ws <= 4'hf;
    axi_rd(`SSQ_ADDR_STAT, s, `SSQ_RESP_OKAY);
    check(s, 32'h1);
    $display("register access test ended");
    run_root(1'b0, 4'h1, 5'h0c);
    run_root(1'b1, 4'h0, 5'h0d);
    give_verdict();
  end
  // both roots need some five thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule
`default_nettype wire
